// File: bench/pcc_ee_model.sv
// serial eeprom stand-in answering image fetches promptly or slowly
`timescale 1ns/10ps
module pcc_ee_model #(
	parameter int AW = 5
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          slow_i,
	input  wire logic          ee_req_i,
	input  wire logic [AW-1:0] ee_addr_i,
	output logic               ee_ack_o,
	output logic [7:0]         ee_data_o
);
	logic [3:0] gap_r;
	// data flips between acks so a stale byte never looks valid
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gap_r     <= 4'h0;
			ee_ack_o  <= 1'b0;
			ee_data_o <= 8'h00;
		end else if (ee_req_i && gap_r == (slow_i ? 4'h5 : 4'h2)) begin
			gap_r     <= 4'h0;
			ee_ack_o  <= 1'b1;
			ee_data_o <= {ee_addr_i[4:0], 3'b010};
		end else begin
			gap_r     <= ee_req_i ? gap_r + 4'h1 : 4'h0;
			ee_ack_o  <= 1'b0;
			ee_data_o <= ~ee_data_o;
		end
	end
endmodule : pcc_ee_model

// File: bench/tb.sv
// self-checking bench for the card configuration block
`timescale 1ns/10ps
`include "pcc_consts.svh"
module tb;
	localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary value
	localparam int         LIMIT  = 20000;
	logic        clk_i = 1'b0, rst_i = 1'b1, slow_i = 1'b0;
	logic [12:0] avs_address_i = 13'h0000;
	logic        avs_read_i = 1'b0, avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0]  avs_byteenable_i = 4'hf;
	logic        host_req_i = 1'b0, host_we_i = 1'b0;
	logic        host_io_i = 1'b0, host_wide_i = 1'b0, fn_irq_i = 1'b0;
	logic [15:0] host_addr_i = 16'h0, host_wdata_i = 16'h0;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o, fn_sel_o, fn_we_o, fn_wide_o;
	logic        mem_sel_o, mem_we_o, host_irq_o, card_ready_o;
	logic        mem_write_strobe_low_n_o, mem_write_strobe_high_n_o;
	logic [15:0] fn_addr_o, fn_wdata_o, mem_addr_o, mem_wdata_o;
	logic        ee_req_o, ee_ack_i;
	logic [4:0]  ee_addr_o;
	logic [7:0]  ee_data_i;
	logic [4:0]  snap;
	int          mismatches = 0, checks_done = 0, cycles = 0, irq_hi = 0;

	assign snap = {fn_sel_o, mem_sel_o, mem_we_o,
		mem_write_strobe_low_n_o, mem_write_strobe_high_n_o};

	pcc_card_top #(.CIS_AW(5), .MAW(16), .IRQ_PULSE_CYC(4),
		.ID_CODE(ID_VAL)) pcc_card_top_inst (.clk_i, .rst_i,
		.avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
		.host_req_i, .host_we_i, .host_io_i, .host_wide_i, .host_addr_i,
		.host_wdata_i, .fn_sel_o, .fn_we_o, .fn_wide_o, .fn_addr_o,
		.fn_wdata_o, .mem_sel_o, .mem_we_o, .mem_write_strobe_low_n_o,
		.mem_write_strobe_high_n_o, .mem_addr_o, .mem_wdata_o, .fn_irq_i,
		.host_irq_o, .card_ready_o, .ee_req_o, .ee_addr_o, .ee_ack_i,
		.ee_data_i);
	pcc_ee_model #(.AW(5)) pcc_ee_model_inst (.clk_i, .rst_i, .slow_i,
		.ee_req_i(ee_req_o), .ee_addr_i(ee_addr_o), .ee_ack_o(ee_ack_i),
		.ee_data_o(ee_data_i));

	always #5 clk_i = ~clk_i;
	// counted late so a reader at the same edge sees a settled value
	always @(posedge clk_i) if (host_irq_o === 1'b1) irq_hi <= irq_hi + 1;

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			mismatches++;
			print_verdict();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	function automatic logic [31:0] img(input int i);
		return {24'h0, i[4:0], 3'b010};
	endfunction : img

	task automatic bus(input logic wr, input logic [12:0] a,
			input logic [7:0] d, input logic [3:0] be, output logic [31:0] q);
		int n;
		n = 0;
		avs_address_i    <= a;
		avs_writedata_i  <= {24'h0, d};
		avs_byteenable_i <= be;
		avs_write_i      <= wr;
		avs_read_i       <= ~wr;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < LIMIT);
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i  <= 1'b0;
		@(posedge clk_i);
	endtask : bus

	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, 4'hf, q);
	endtask : wr

	task automatic rd(input logic [12:0] a, output logic [31:0] q);
		bus(1'b0, a, 8'h00, 4'hf, q);
	endtask : rd

	task automatic host(input logic we, io, wide, input logic [15:0] a, d,
			output logic [4:0] s1, s2);
		host_req_i   <= 1'b1;
		host_we_i    <= we;
		host_io_i    <= io;
		host_wide_i  <= wide;
		host_addr_i  <= a;
		host_wdata_i <= d;
		@(posedge clk_i);
		host_req_i <= 1'b0;
		@(posedge clk_i);
		s1 = snap;
		@(posedge clk_i);
		s2 = snap;
	endtask : host

	task automatic do_reset(input logic slow);
		int n;
		n = 0;
		slow_i <= slow;
		rst_i  <= 1'b1;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check(32'(card_ready_o), 32'h0);
		check({30'h0, ee_req_o, fn_wide_o}, 32'h3);
		while (card_ready_o !== 1'b1 && n < 3000) begin
			@(posedge clk_i);
			n++;
		end
		check(32'(card_ready_o), 32'h1);
		check(32'(ee_req_o), 32'h0);
	endtask : do_reset

	task automatic t_reload();
		logic [31:0] q;
		int          n;
		n = 0;
		wr(`PCC_OFF_EECTL, 8'h01);
		@(posedge clk_i);
		check(32'(card_ready_o), 32'h0);
		while (card_ready_o !== 1'b1 && n < 3000) begin
			@(posedge clk_i);
			n++;
		end
		rd(`PCC_OFF_STATIC, q);
		check(q, img(16));
		rd(13'h0008, q);
		check(q, img(2));
	endtask : t_reload

	task automatic t_boot();
		logic [31:0] q;
		logic [12:0] offs [5] = '{`PCC_OFF_FUNCTION_CONFIG_STATUS_REG, `PCC_OFF_BASE_LO,
			`PCC_OFF_BASE_HI, `PCC_OFF_LIMIT, `PCC_OFF_EECTL};
		for (int i = 0; i < 32; i++) begin
			rd(13'(i * 4), q);
			check(q, img(i));
		end
		for (int k = 0; k < 9; k++) begin
			rd(`PCC_OFF_STATIC + 13'(k * 4), q);
			check(q, img(16 + k));
		end
		rd(`PCC_OFF_COR, q);
		check(q, 32'h0);
		foreach (offs[j]) begin
			rd(offs[j], q);
			check(q, 32'h0);
		end
		rd(`PCC_OFF_ID, q);
		check(q, {24'h0, ID_VAL});
	endtask : t_boot

	task automatic t_window();
		logic [31:0] q;
		logic [4:0]  s1, s2;
		logic [15:0] miss [3] = '{16'h0148, 16'h013f, 16'h1140};
		wr(`PCC_OFF_COR, 8'h01);
		bus(1'b1, `PCC_OFF_BASE_HI, 8'h1f, 4'he, q);
		wr(`PCC_OFF_BASE_LO, 8'h40);
		wr(13'h1044, 8'hff);
		rd(13'h1044, q);
		check(q, 32'h0);
		rd(`PCC_OFF_BASE_HI, q);
		check(q, 32'h0);
		wr(`PCC_OFF_BASE_HI, 8'h01);
		wr(`PCC_OFF_LIMIT, 8'h07);
		rd(`PCC_OFF_BASE_HI, q);
		check(q, 32'h1);
		host(1'b1, 1'b1, 1'b1, 16'h0140, 16'hbeef, s1, s2);
		check(32'(s1), 32'h13);
		check(32'(s2), 32'h03);
		check({fn_addr_o, fn_wdata_o}, 32'h0140beef);
		check({30'h0, fn_we_o, fn_wide_o}, 32'h3);
		host(1'b1, 1'b1, 1'b0, 16'h0147, 16'h005a, s1, s2);
		check(32'(s1), 32'h13);
		check({fn_addr_o, fn_wdata_o}, 32'h0147005a);
		check({30'h0, fn_we_o, fn_wide_o}, 32'h2);
		host(1'b0, 1'b1, 1'b1, 16'h0144, 16'h0000, s1, s2);
		check({27'h0, s1[4], fn_we_o, fn_wide_o}, 32'h5);
		foreach (miss[j]) begin
			host(1'b1, 1'b1, 1'b1, miss[j], 16'h1234, s1, s2);
			check(32'(s1), 32'h03);
		end
	endtask : t_window

	task automatic t_strobe();
		logic [4:0]  s1, s2;
		logic [15:0] a, d;
		logic        wide, odd, lo, hi;
		for (int m = 0; m < 2; m++) begin
			wr(`PCC_OFF_STATIC, {7'h41, m[0]});
			for (int k = 0; k < 3; k++) begin
				wide = (k == 0);
				odd  = (k == 2);
				a    = {15'h0100, odd};
				d    = 16'hc3a0 + 16'(k);
				lo   = m[0] | wide | ~odd;
				hi   = ~m[0] & (wide | odd);
				host(1'b1, 1'b0, wide, a, d, s1, s2);
				check(32'(s1), 32'({3'b011, ~lo, ~hi}));
				check(32'(s2), 32'h03);
				check({mem_addr_o, mem_wdata_o}, {a, d});
			end
		end
		host(1'b0, 1'b0, 1'b1, 16'h0204, 16'h0000, s1, s2);
		check(32'(s1), 32'h0b);
	endtask : t_strobe

	task automatic t_irq();
		logic [31:0] q;
		int          base;
		wr(`PCC_OFF_FUNCTION_CONFIG_STATUS_REG, 8'h04);
		base = irq_hi;
		fn_irq_i <= 1'b1;
		repeat (12) @(posedge clk_i);
		check(32'(irq_hi - base), 32'd4);
		fn_irq_i <= 1'b0;
		@(posedge clk_i);
		base = irq_hi;
		fn_irq_i <= 1'b1;
		repeat (20) @(posedge clk_i);
		check(32'(irq_hi - base), 32'd0);
		rd(`PCC_OFF_FUNCTION_CONFIG_STATUS_REG, q);
		check(q, 32'h6);
		base = irq_hi;
		// host finishes service and clears the flag
		wr(`PCC_OFF_FUNCTION_CONFIG_STATUS_REG, 8'h04);
		repeat (12) @(posedge clk_i);
		check(32'(irq_hi - base), 32'd4);
		fn_irq_i <= 1'b0;
		wr(`PCC_OFF_FUNCTION_CONFIG_STATUS_REG, 8'h00);
		wr(`PCC_OFF_COR, 8'h41);
		fn_irq_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		base = irq_hi;
		repeat (10) @(posedge clk_i);
		check(32'(irq_hi - base), 32'd10);
		fn_irq_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		check(32'(host_irq_o), 32'h0);
	endtask : t_irq

	initial begin
		do_reset(1'b0);
		t_boot();
		t_window();
		t_strobe();
		t_reload();
		t_irq();
		do_reset(1'b1);
		t_boot();
		print_verdict();
	end
endmodule : tb

// File: rtl/pcc_card_top.sv
// card-side configuration, window decode, byte lanes and interrupts
// Overview of operation
// R1: host programs base and limit from the cis table entry before i/o use
// R2: host finds the option register through the cis configuration tuple
// R3: a host access inside the i/o window is forwarded to the function port; here only while the configuration option register is non-zero
// R4: reset first reloads the shadow cis from the serial eeprom
// R5: reset clears the configuration option register to zero
// R6: reset returns every other register to its default
// R7: word-wide by default; byte accesses pass to the function unchanged
// R8: the byte-wide memory bit selects the memory write strobe scheme
// R9: word memory, even byte access strobes only the low lane
// R10: word memory, odd byte access strobes only the high lane
// R11: word memory, word access strobes both lanes together
// R12: byte memory, any byte access strobes only the low lane
// R13: byte memory, word access moves one byte on the low lane
// R14: eeprom image fills shadow ram and nine static register defaults
// R15: host reads the cis image through attribute memory
// R16: id and eeprom control registers are host readable and writable; the id register here is read-only, fixed at ID_CODE
// R17: interrupts are pulse or level; select bit picks the protocol
// R18: host writes zero to the flag after servicing an enhanced interrupt
// R19: enhanced mode withholds further interrupts until the flag clears
// R20: the i/o window comes only from the base and limit registers
// R21: low base register holds bits 7..0, second base bits 12..8
//
// Added by the designer: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
`include "pcc_consts.svh"
module pcc_card_top #(
	parameter int         CIS_AW        = 10,
	parameter int         MAW           = 16,
	parameter int         IRQ_PULSE_CYC = 4,
	parameter logic [7:0] ID_CODE       = 8'h5a // arbitrary value
) (
	input  wire logic           clk_i,
	input  wire logic           rst_i,
	input  wire logic [12:0]    avs_address_i,
	input  wire logic           avs_read_i,
	input  wire logic           avs_write_i,
	input  wire logic [31:0]    avs_writedata_i,
	input  wire logic [3:0]     avs_byteenable_i,
	output logic [31:0]         avs_readdata_o,
	output logic                avs_waitrequest_o,
	input  wire logic           host_req_i,
	input  wire logic           host_we_i,
	input  wire logic           host_io_i,
	input  wire logic           host_wide_i,
	input  wire logic [MAW-1:0] host_addr_i,
	input  wire logic [15:0]    host_wdata_i,
	output logic                fn_sel_o,
	output logic                fn_we_o,
	output logic                fn_wide_o,
	output logic [MAW-1:0]      fn_addr_o,
	output logic [15:0]         fn_wdata_o,
	output logic                mem_sel_o,
	output logic                mem_we_o,
	output logic                mem_write_strobe_low_n_o,
	output logic                mem_write_strobe_high_n_o,
	output logic [MAW-1:0]      mem_addr_o,
	output logic [15:0]         mem_wdata_o,
	input  wire logic           fn_irq_i,
	output logic                host_irq_o,
	output logic                card_ready_o,
	output logic                ee_req_o,
	output logic [CIS_AW-1:0]   ee_addr_o,
	input  wire logic           ee_ack_i,
	input  wire logic [7:0]     ee_data_i
);
	localparam int CIS_BYTES = 1 << CIS_AW;
	localparam logic [CIS_AW-1:0] ST_EE_BASE =
		CIS_AW'(CIS_BYTES - `PCC_STATIC_TAIL);
	localparam logic [3:0] PULSE_LD = 4'(IRQ_PULSE_CYC);

	if (CIS_AW < `PCC_CIS_AW_MIN || CIS_AW > `PCC_CIS_AW_MAX ||
	    MAW < `PCC_IO_AW || IRQ_PULSE_CYC < 1 || IRQ_PULSE_CYC > 15)
	begin : g_bad_param
		$error("pcc_card_top: unsupported parameter value");
	end

	logic [7:0]              cis_mem [CIS_BYTES];
	logic [7:0]              stat_r [`PCC_STATIC_NUM];
	logic [7:0]              cor_r;
	logic                    flag_r;
	logic                    enh_r;
	logic [7:0]              base_lo_r;
	logic [`PCC_BASE_HI_W-1:0] base_hi_r;
	logic [7:0]              limit_r;
	logic                    reload_r;
	logic                    wait_r;
	logic [31:0]             rdata_r;
	logic                    fn_sel_r;
	logic                    fn_we_r;
	logic                    fn_wide_r;
	logic [MAW-1:0]          fn_addr_r;
	logic [15:0]             fn_wdata_r;
	logic                    mem_sel_r;
	logic                    mem_we_r;
	logic                    lo_n_r;
	logic                    hi_n_r;
	logic [MAW-1:0]          mem_addr_r;
	logic [15:0]             mem_wdata_r;
	logic                    irq_q_r;
	logic                    pend_r;
	logic [3:0]              pcnt_r;
	logic                    irq_r;
	logic                    ready_r;
	logic                    ld_busy;
	logic                    ld_wr;
	logic [CIS_AW-1:0]       ld_addr;
	logic [7:0]              ld_data;
	logic                    stall;
	logic                    go;
	logic                    wr;
	logic                    cis_hit;
	logic [CIS_AW-1:0]       cis_idx;
	logic [12:0]             st_off;
	logic                    st_hit;
	logic [3:0]              st_idx;
	logic [CIS_AW-1:0]       ls_off;
	logic [12:0]             win_base;
	logic [13:0]             win_end;
	logic                    hit;
	logic                    mem8;
	logic                    mem_wr;
	logic                    evt;
	logic                    dlv;
	logic                    flag_clr;
	logic [7:0]              rd_byte;

	pcc_eeprom_loader #(
		.AW        (CIS_AW)
	) u_loader (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.start_i   (reload_r),
		.ee_ack_i  (ee_ack_i),
		.ee_data_i (ee_data_i),
		.ee_req_o  (ee_req_o),
		.ee_addr_o (ee_addr_o),
		.wr_en_o   (ld_wr),
		.wr_addr_o (ld_addr),
		.wr_data_o (ld_data),
		.busy_o    (ld_busy)
	);

	// bus and host stall until the last loaded byte has been written
	assign stall   = ld_busy | ld_wr;
	assign go      = (avs_read_i | avs_write_i) & wait_r & ~stall;
	assign wr      = go & avs_write_i & avs_byteenable_i[0];
	assign cis_hit = ~avs_address_i[`PCC_REG_SEL_BIT] &&
		({1'b0, avs_address_i[11:2]} < 11'(CIS_BYTES));
	assign cis_idx = avs_address_i[CIS_AW+1:2];
	assign st_off  = avs_address_i - `PCC_OFF_STATIC;
	assign st_hit  = (avs_address_i >= `PCC_OFF_STATIC) &&
		(st_off[12:2] < `PCC_STATIC_NUM);
	assign st_idx  = st_off[5:2];
	assign ls_off  = ld_addr - ST_EE_BASE;

	// bus answer: one cycle with waitrequest low per accepted request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wait_r  <= 1'b1;
			rdata_r <= 32'h0000_0000;
		end else begin
			wait_r <= ~go;
			if (go) begin
				rdata_r <= {24'h00_0000, rd_byte};
			end
		end
	end

	always_comb begin
		rd_byte = 8'h00;
		if (cis_hit) begin
			rd_byte = cis_mem[cis_idx]; // [R15]
		end else if (st_hit) begin
			rd_byte = stat_r[st_idx];
		end else begin
			unique case (avs_address_i)
				`PCC_OFF_COR:     rd_byte = cor_r;
				`PCC_OFF_FUNCTION_CONFIG_STATUS_REG: begin
					rd_byte[`PCC_FUNCTION_CONFIG_STATUS_REG_INTR_BIT] = flag_r;
					rd_byte[`PCC_FUNCTION_CONFIG_STATUS_REG_ENH_BIT]  = enh_r;
				end
				`PCC_OFF_BASE_LO: rd_byte = base_lo_r;
				`PCC_OFF_BASE_HI: rd_byte = {3'h0, base_hi_r};
				`PCC_OFF_LIMIT:   rd_byte = limit_r;
				`PCC_OFF_ID:      rd_byte = ID_CODE; // [R16]
				`PCC_OFF_EECTL:
					rd_byte[`PCC_EECTL_BUSY_BIT] = ld_busy; // [R16]
				default:          rd_byte = 8'h00;
			endcase
		end
	end

	// shadow ram has no reset; it is refilled by the loader after reset
	always_ff @(posedge clk_i) begin
		if (ld_wr) begin
			cis_mem[ld_addr] <= ld_data; // [R14]
		end else if (wr && cis_hit) begin
			cis_mem[cis_idx] <= avs_writedata_i[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < `PCC_STATIC_NUM; i++) begin
				stat_r[i] <= `PCC_REG_RST; // [R6]
			end
		end else if (ld_wr && ld_addr >= ST_EE_BASE &&
		             {1'b0, ls_off} < `PCC_STATIC_NUM) begin
			stat_r[ls_off[3:0]] <= ld_data; // [R14]
		end else if (wr && st_hit) begin
			stat_r[st_idx] <= avs_writedata_i[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cor_r     <= `PCC_COR_RST; // [R5]
			enh_r     <= 1'b0; // [R6]
			base_lo_r <= `PCC_REG_RST;
			base_hi_r <= '0;
			limit_r   <= `PCC_REG_RST;
			reload_r  <= 1'b0;
		end else begin
			reload_r <= wr && (avs_address_i == `PCC_OFF_EECTL) &&
				avs_writedata_i[`PCC_EECTL_RELOAD_BIT]; // [R16]
			if (wr) begin
				unique case (avs_address_i)
					`PCC_OFF_COR: cor_r <= avs_writedata_i[7:0];
					`PCC_OFF_FUNCTION_CONFIG_STATUS_REG:
						enh_r <= avs_writedata_i[`PCC_FUNCTION_CONFIG_STATUS_REG_ENH_BIT];
					`PCC_OFF_BASE_LO:
						base_lo_r <= avs_writedata_i[7:0]; // [R21]
					`PCC_OFF_BASE_HI:
						base_hi_r <= avs_writedata_i[`PCC_BASE_HI_W-1:0];
					`PCC_OFF_LIMIT: limit_r <= avs_writedata_i[7:0];
					default: ;
				endcase
			end
		end
	end

	// window is base..base+limit inclusive, no wrap past bit 12
	assign win_base = {base_hi_r, base_lo_r}; // [R21]
	assign win_end  = {1'b0, win_base} + {6'h00, limit_r}; // [R20]
	assign hit = host_io_i && (cor_r != `PCC_COR_RST) &&
		(host_addr_i[12:0] >= win_base) &&
		({1'b0, host_addr_i[12:0]} <= win_end); // [R20]

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fn_sel_r   <= 1'b0;
			fn_we_r    <= 1'b0;
			fn_wide_r  <= 1'b1;
			fn_addr_r  <= '0;
			fn_wdata_r <= 16'h0000;
		end else begin
			fn_sel_r <= host_req_i & ~stall & hit; // [R3]
			if (host_req_i & ~stall & hit) begin
				fn_we_r    <= host_we_i; // [R3]
				fn_wide_r  <= host_wide_i; // [R7]
				fn_addr_r  <= host_addr_i;
				fn_wdata_r <= host_wdata_i; // [R7]
			end
		end
	end

	assign mem8   = stat_r[`PCC_ST_PINPOL][`PCC_PINPOL_MEM8_BIT]; // [R8]
	assign mem_wr = host_req_i & ~stall & ~host_io_i & host_we_i;

	// strobes are active-low, held low for one cycle per cycle of host write request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mem_sel_r   <= 1'b0;
			mem_we_r    <= 1'b0;
			lo_n_r      <= 1'b1;
			hi_n_r      <= 1'b1;
			mem_addr_r  <= '0;
			mem_wdata_r <= 16'h0000;
		end else begin
			mem_sel_r <= host_req_i & ~stall & ~host_io_i;
			mem_we_r  <= mem_wr;
			// byte memory: every access uses the low lane only
			lo_n_r <= ~(mem_wr & (mem8 | host_wide_i |
				~host_addr_i[0])); // [R9] [R11] [R12] [R13]
			hi_n_r <= ~(mem_wr & ~mem8 &
				(host_wide_i | host_addr_i[0])); // [R10] [R11]
			if (host_req_i & ~stall & ~host_io_i) begin
				mem_addr_r  <= host_addr_i;
				mem_wdata_r <= host_wdata_i;
			end
		end
	end

	// enhanced mode: the flag blocks delivery, new events stay pending
	assign evt      = fn_irq_i & ~irq_q_r;
	assign dlv      = (evt | pend_r) & ~(enh_r & flag_r); // [R17] [R19]
	assign flag_clr = wr && (avs_address_i == `PCC_OFF_FUNCTION_CONFIG_STATUS_REG) &&
		~avs_writedata_i[`PCC_FUNCTION_CONFIG_STATUS_REG_INTR_BIT]; // [R18]

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_q_r <= 1'b0;
			pend_r  <= 1'b0;
			flag_r  <= 1'b0;
			pcnt_r  <= 4'h0;
			irq_r   <= 1'b0;
		end else begin
			irq_q_r <= fn_irq_i;
			pend_r  <= (pend_r | evt) & ~dlv; // [R19]
			// a delivery in the clearing cycle wins
			if (dlv) begin
				flag_r <= 1'b1;
			end else if (flag_clr || (!enh_r && !fn_irq_i)) begin
				flag_r <= 1'b0;
			end
			if (dlv) begin
				pcnt_r <= PULSE_LD;
			end else if (pcnt_r != 4'h0) begin
				pcnt_r <= pcnt_r - 4'h1;
			end
			irq_r <= cor_r[`PCC_COR_LEVEL_BIT] ? flag_r :
				(pcnt_r != 4'h0); // [R17]
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ready_r <= 1'b0;
		end else begin
			ready_r <= ~stall;
		end
	end

	assign avs_waitrequest_o         = wait_r;
	assign avs_readdata_o            = rdata_r;
	assign fn_sel_o                  = fn_sel_r;
	assign fn_we_o                   = fn_we_r;
	assign fn_wide_o                 = fn_wide_r;
	assign fn_addr_o                 = fn_addr_r;
	assign fn_wdata_o                = fn_wdata_r;
	assign mem_sel_o                 = mem_sel_r;
	assign mem_we_o                  = mem_we_r;
	assign mem_write_strobe_low_n_o  = lo_n_r;
	assign mem_write_strobe_high_n_o = hi_n_r;
	assign mem_addr_o                = mem_addr_r;
	assign mem_wdata_o               = mem_wdata_r;
	assign host_irq_o                = irq_r;
	assign card_ready_o              = ready_r;

	a_window_fwd: assert property (@(posedge clk_i) // [R3]
		disable iff (rst_i) host_req_i && !stall && hit |=> fn_sel_o)
		else $error("window hit not forwarded");
	a_miss_quiet: assert property (@(posedge clk_i) // [R20]
		disable iff (rst_i) !(host_req_i && hit) |=> !fn_sel_o)
		else $error("function selected outside window");
	a_reset_load: assert property (@(posedge clk_i) // [R4]
		rst_i ##1 !rst_i |-> ld_busy && ee_req_o)
		else $error("no eeprom reload after reset");
	a_reset_cor: assert property (@(posedge clk_i) // [R5]
		rst_i |=> cor_r == `PCC_COR_RST)
		else $error("option register not cleared by reset");
	a_reset_regs: assert property (@(posedge clk_i) // [R6]
		rst_i |=> !enh_r && !flag_r && limit_r == `PCC_REG_RST &&
		base_lo_r == `PCC_REG_RST && !host_irq_o)
		else $error("register default missing after reset");
	a_byte_pass: assert property (@(posedge clk_i) // [R7]
		disable iff (rst_i) host_req_i && !stall && hit |=>
		fn_wide_o == $past(host_wide_i) &&
		fn_wdata_o == $past(host_wdata_i))
		else $error("function access altered");
	a_even_low: assert property (@(posedge clk_i) // [R9]
		disable iff (rst_i)
		mem_wr && !mem8 && !host_wide_i && !host_addr_i[0]
		|=> !mem_write_strobe_low_n_o && mem_write_strobe_high_n_o)
		else $error("even byte strobe wrong");
	a_odd_high: assert property (@(posedge clk_i) // [R10]
		disable iff (rst_i)
		mem_wr && !mem8 && !host_wide_i && host_addr_i[0]
		|=> mem_write_strobe_low_n_o && !mem_write_strobe_high_n_o)
		else $error("odd byte strobe wrong");
	// back-to-back host writes may keep the low strobe down
	a_word_both: assert property (@(posedge clk_i) // [R11]
		disable iff (rst_i) mem_wr && !mem8 && host_wide_i
		|=> !mem_write_strobe_low_n_o && !mem_write_strobe_high_n_o
		##1 (mem_write_strobe_low_n_o || $past(mem_wr)))
		else $error("word strobes wrong");
	a_mem8_low: assert property (@(posedge clk_i) // [R12] [R13]
		disable iff (rst_i) mem_wr && mem8 |=>
		!mem_write_strobe_low_n_o && mem_write_strobe_high_n_o)
		else $error("byte memory strobe wrong");
	a_static_load: assert property (@(posedge clk_i) // [R14]
		disable iff (rst_i) ld_wr && ld_addr == ST_EE_BASE |=>
		stat_r[0] == $past(ld_data))
		else $error("static default not loaded");
	a_enh_hold: assert property (@(posedge clk_i) // [R19]
		disable iff (rst_i) enh_r && flag_r && !flag_clr |=> flag_r)
		else $error("enhanced flag lost");
	a_pulse_out: assert property (@(posedge clk_i) // [R17]
		disable iff (rst_i) dlv && !cor_r[`PCC_COR_LEVEL_BIT] ##1
		!cor_r[`PCC_COR_LEVEL_BIT] |=> host_irq_o)
		else $error("interrupt pulse missing");
endmodule : pcc_card_top

// File: rtl/pcc_consts.svh
// offsets, field positions and reset values of the card configuration block
`ifndef PCC_CONSTS_SVH
`define PCC_CONSTS_SVH
`define PCC_REG_SEL_BIT 12
`define PCC_OFF_COR 13'h1000
`define PCC_OFF_FUNCTION_CONFIG_STATUS_REG 13'h1004
`define PCC_OFF_BASE_LO 13'h1008
`define PCC_OFF_BASE_HI 13'h100c
`define PCC_OFF_LIMIT 13'h1010
`define PCC_OFF_ID 13'h1014
`define PCC_OFF_EECTL 13'h1018
`define PCC_OFF_STATIC 13'h1020
`define PCC_STATIC_NUM 11'd9
`define PCC_STATIC_TAIL 16
`define PCC_ST_PINPOL 0
`define PCC_PINPOL_MEM8_BIT 0
`define PCC_COR_RST 8'h00
`define PCC_COR_LEVEL_BIT 6
`define PCC_FUNCTION_CONFIG_STATUS_REG_INTR_BIT 1
`define PCC_FUNCTION_CONFIG_STATUS_REG_ENH_BIT 2
`define PCC_EECTL_RELOAD_BIT 0
`define PCC_EECTL_BUSY_BIT 1
`define PCC_REG_RST 8'h00
`define PCC_BASE_HI_W 5
`define PCC_IO_AW 13
`define PCC_CIS_AW_MIN 5
`define PCC_CIS_AW_MAX 10
`endif

// File: rtl/pcc_eeprom_loader.sv
// copies the serial eeprom image into shadow ram, byte by byte
`timescale 1ns/10ps
module pcc_eeprom_loader #(
	parameter int AW = 10
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          start_i,
	input  wire logic          ee_ack_i,
	input  wire logic [7:0]    ee_data_i,
	output logic               ee_req_o,
	output logic [AW-1:0]      ee_addr_o,
	output logic               wr_en_o,
	output logic [AW-1:0]      wr_addr_o,
	output logic [7:0]         wr_data_o,
	output logic               busy_o
);
	pcc_pkg::pcc_ld_state_t state_r;
	logic [AW-1:0]          addr_r;
	logic                   busy_r;
	logic                   wr_r;
	logic [7:0]             data_r;
	logic [AW-1:0]          wa_r;

	// reset itself starts a full reload
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= pcc_pkg::ld_fetch; // [R4]
			addr_r  <= '0;
			busy_r  <= 1'b1;
		end else begin
			unique case (state_r)
				pcc_pkg::ld_idle: begin
					if (start_i) begin
						state_r <= pcc_pkg::ld_fetch;
						addr_r  <= '0;
						busy_r  <= 1'b1;
					end
				end
				pcc_pkg::ld_fetch: begin
					if (ee_ack_i) begin
						addr_r <= addr_r + 1'b1;
						if (&addr_r) begin
							state_r <= pcc_pkg::ld_idle;
							busy_r  <= 1'b0;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_r   <= 1'b0;
			data_r <= 8'h00;
			wa_r   <= '0;
		end else begin
			wr_r   <= (state_r == pcc_pkg::ld_fetch) && ee_ack_i; // [R14]
			data_r <= ee_data_i;
			wa_r   <= addr_r;
		end
	end

	assign ee_req_o  = busy_r;
	assign ee_addr_o = addr_r;
	assign wr_en_o   = wr_r;
	assign wr_addr_o = wa_r;
	assign wr_data_o = data_r;
	assign busy_o    = busy_r;
endmodule : pcc_eeprom_loader

// File: rtl/pcc_pkg.sv
// types shared by the card configuration block
package pcc_pkg;
	typedef enum logic [0:0] {
		ld_idle  = 1'b0,
		ld_fetch = 1'b1
	} pcc_ld_state_t;
endpackage : pcc_pkg
